// ==== src/rtcpf_clock_pf.sv ====
// Function
// (R1) power fail deselects, blocks register access
// (R2) reset output active until supply nominal
// (R3) sram enable forced high while out of tolerance
// (R4) power-up deselect interval keeps sram disabled
// (R5) reset stays active through deselect interval
// (R6) all outputs high impedance on battery
// (R7) fast fall may delay deselect 200 us
// (R8) eight bcd clock registers hold time
// (R9) century flag toggles only when enabled
// (R10) day of week, date, month, year registers
// (R11) control register accessible on its own
// (R12) stop bit halts timekeeping, not the 32 kHz tick
// (R13) clearing stop bit resumes counting promptly
// (R14) clock reads suspend user copy updates
// (R15) power fail sets freeze bit automatically
// (R16) host clears freeze bit to resume updates
// (R17) power fail aborts access, clears pointer
// (R18) updates resume on deselect or non-clock address
// (R19) clock register write resets divider chain
// (R20) supply comparators are digital inputs
// (R21) deselect interval counted on 32 kHz ticks
`include "rtcpf_regs.svh"

module rtcpf_clock_pf #(
	parameter int OSC_DIV = `RTCPF_CLK_HZ / `RTCPF_OSC_HZ
) (
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  rtcpf_pkg::rtcpf_spi_in_t   spi_in,
	output wire logic                  sdo,
	output wire logic                  sdo_oe_n,
	input  rtcpf_pkg::rtcpf_supply_t   supply,
	input  wire logic                  ext_ce_n,
	output wire logic                  sram_enable_out,
	output wire logic                  sram_oe_n,
	output wire logic                  cpu_reset_n,
	output wire logic                  cpu_reset_oe_n
);
	import rtcpf_pkg::*;

	// deselect interval lengths in 32 kHz ticks, rounded up
	localparam int POWER_UP_DESELECT_TIME_SHORT_TK =
		(`RTCPF_POWER_UP_DESELECT_TIME_SHORT_US * `RTCPF_OSC_HZ + 999999) / 1000000;
	localparam int POWER_UP_DESELECT_TIME_LONG_TK =
		(`RTCPF_POWER_UP_DESELECT_TIME_LONG_US * `RTCPF_OSC_HZ + 999999) / 1000000;

	// true for the eight timekeeping addresses
	function automatic logic is_clock_addr(input logic [5:0] a);
		return a < `RTCPF_CLOCK_REGS;
	endfunction : is_clock_addr

	// synchronisers: stage one feeds stage two only
	rtcpf_spi_in_t  spi_s1_ff;
	rtcpf_spi_in_t  spi_s2_ff;
	rtcpf_spi_in_t  spi_s3_ff;
	rtcpf_supply_t  sup_s1_ff;
	rtcpf_supply_t  sup_s2_ff;
	logic           ext_s1_ff;
	logic           ext_s2_ff;

	// power sequencing
	rtcpf_pwr_t     pstate_ff;
	rtcpf_pwr_t     nxt_pstate;
	logic [6:0]     rec_ff;

	// serial engine
	logic [2:0]     bitcnt_ff;
	logic           data_ph_ff;
	logic           wr_ff;
	logic [5:0]     ptr_ff;
	logic [6:0]     rx_ff;
	logic [7:0]     tx_ff;
	logic           sdo_ff;
	logic           sdo_oe_n_ff;

	// user-visible registers
	rtcpf_time_t    user_ff;
	logic [7:0]     ctrl_ff;
	logic           freeze_ff;

	// pin outputs
	logic           sram_en_ff;
	logic           sram_oe_n_ff;
	logic           rst_n_ff;
	logic           rst_oe_n_ff;

	// internal time and the derived 32 kHz enable
	rtcpf_time_t    time_int;
	logic           tick_32k;

	// every pin passes two flops before any logic sees it
	always_ff @(posedge clk) begin
		spi_s1_ff <= spi_in;
		spi_s2_ff <= spi_s1_ff;
		spi_s3_ff <= spi_s2_ff;
		sup_s1_ff <= supply; // see (R20)
		sup_s2_ff <= sup_s1_ff;
		ext_s1_ff <= ext_ce_n;
		ext_s2_ff <= ext_s1_ff;
	end

	// power state decode
	wire pf_now    = sup_s2_ff.pwr_fail;
	wire batt_now  = sup_s2_ff.on_battery;
	wire ok_now    = sup_s2_ff.supply_ok;
	wire rec_done  = rec_ff == 7'h00;
	wire running   = pstate_ff == PS_RUN;
	wire on_batt   = pstate_ff == PS_BATT;
	wire enter_rec = (pstate_ff != PS_REC) && (nxt_pstate == PS_REC);
	wire pf_event  = (pstate_ff != PS_FAIL) && (nxt_pstate == PS_FAIL);
	wire power_up_deselect_time_sel  = time_int[`RTCPF_IDX_DOW][`RTCPF_BIT_POWER_UP_DESELECT_TIME_SEL];
	wire [6:0] rec_load = power_up_deselect_time_sel ? 7'(POWER_UP_DESELECT_TIME_SHORT_TK)
		: 7'(POWER_UP_DESELECT_TIME_LONG_TK);

	// deselect reacts within a few clocks, far inside the 200 us allowance
	always_comb begin
		nxt_pstate = pstate_ff;
		unique case (pstate_ff)
			PS_RUN: begin
				if (pf_now)
					nxt_pstate = PS_FAIL; // see (R1) (R7)
			end
			PS_FAIL: begin
				if (batt_now)
					nxt_pstate = PS_BATT;
				else if (ok_now && !pf_now)
					nxt_pstate = PS_REC; // see (R2)
			end
			PS_BATT: begin
				if (!batt_now)
					nxt_pstate = PS_FAIL;
			end
			PS_REC: begin
				if (pf_now)
					nxt_pstate = PS_FAIL;
				else if (rec_done)
					nxt_pstate = PS_RUN; // see (R4) (R5)
			end
		endcase
	end

	// reset lands in the recovery interval, like a power-up
	always_ff @(posedge clk) begin
		if (srst)
			pstate_ff <= PS_REC;
		else
			pstate_ff <= nxt_pstate;
	end

	// deselect interval counter, loaded from the interval setting
	always_ff @(posedge clk) begin
		if (srst)
			rec_ff <= 7'(POWER_UP_DESELECT_TIME_LONG_TK);
		else if (enter_rec)
			rec_ff <= rec_load; // see (R21)
		else if (pstate_ff == PS_REC && tick_32k && !rec_done)
			rec_ff <= rec_ff - 7'h01; // see (R21)
	end

	// serial decode; access only while the supply is in tolerance
	wire       scl_rise  = spi_s2_ff.scl & ~spi_s3_ff.scl;
	wire       scl_fall  = ~spi_s2_ff.scl & spi_s3_ff.scl;
	wire       spi_en    = running & ~spi_s2_ff.ce_n; // see (R1)
	wire       byte_done = spi_en & scl_rise & (bitcnt_ff == 3'h7);
	wire [7:0] rx_byte   = {rx_ff, spi_s2_ff.sdi};
	wire       cmd_done  = byte_done & ~data_ph_ff;
	wire       data_done = byte_done & data_ph_ff;
	wire [5:0] ptr_inc   = ptr_ff + 6'h01;
	wire [5:0] rd_addr   = cmd_done ? rx_byte[5:0] : ptr_inc;
	wire       wr_stb    = data_done & wr_ff;
	wire       wr_clock  = wr_stb & is_clock_addr(ptr_ff);
	wire       wr_ctrl   = wr_stb & (ptr_ff == `RTCPF_ADDR_CTRL);
	wire       wr_hold   = wr_stb & (ptr_ff == `RTCPF_ADDR_HOLD);

	// read mux: clock copy, control, freeze bit, zero elsewhere
	wire [7:0] rd_byte =
		is_clock_addr(rd_addr) ? user_ff[rd_addr[2:0]]
		: (rd_addr == `RTCPF_ADDR_CTRL) ? ctrl_ff // see (R11)
		: (rd_addr == `RTCPF_ADDR_HOLD)
			? {1'b0, freeze_ff, 6'h00}
		: 8'h00;

	// frame state; bit 6 of the command is a don't care
	always_ff @(posedge clk) begin
		if (srst || !spi_en) begin
			bitcnt_ff  <= 3'h0; // see (R17)
			data_ph_ff <= 1'b0;
			wr_ff      <= 1'b0;
			ptr_ff     <= 6'h00; // see (R17)
		end else if (scl_rise) begin
			bitcnt_ff <= bitcnt_ff + 3'h1;
			if (cmd_done) begin
				data_ph_ff <= 1'b1;
				wr_ff      <= rx_byte[7];
				ptr_ff     <= rx_byte[5:0];
			end else if (data_done) begin
				ptr_ff <= ptr_inc; // wraps 3Fh to 00h
			end
		end
	end

	// receive shift on rising scl
	always_ff @(posedge clk) begin
		if (srst)
			rx_ff <= 7'h00;
		else if (spi_en && scl_rise)
			rx_ff <= rx_byte[6:0];
	end

	// transmit: load at byte end, present msb on the next falling scl
	always_ff @(posedge clk) begin
		if (srst || !spi_en) begin
			tx_ff  <= 8'h00;
			sdo_ff <= 1'b0;
		end else if (cmd_done || data_done) begin
			tx_ff <= rd_byte;
		end else if (scl_fall && data_ph_ff && !wr_ff) begin
			sdo_ff <= tx_ff[7];
			tx_ff  <= {tx_ff[6:0], 1'b0};
		end
	end

	// data pin drives only during a read data phase
	always_ff @(posedge clk) begin
		if (srst)
			sdo_oe_n_ff <= 1'b1;
		else
			sdo_oe_n_ff <= ~(spi_en & data_ph_ff & ~wr_ff) | on_batt;
	end

	// copying stops while the pointer sits on a clock address during a selected data phase
	wire clock_hold  = spi_en & data_ph_ff & is_clock_addr(ptr_ff);
	wire user_update = ~freeze_ff & ~clock_hold; // see (R14) (R18)

	// user copy; a host write lands in both copies at once
	always_ff @(posedge clk) begin
		if (srst)
			user_ff <= time_int;
		else if (wr_clock)
			user_ff[ptr_ff[2:0]] <= rx_byte;
		else if (user_update)
			user_ff <= time_int; // see (R16)
	end

	// control byte is plain storage here, no calibration behind it
	always_ff @(posedge clk) begin
		if (srst)
			ctrl_ff <= `RTCPF_CTRL_RST;
		else if (wr_ctrl)
			ctrl_ff <= rx_byte; // see (R11)
	end

	// freeze bit: power fail sets it, and the set beats a host clear
	always_ff @(posedge clk) begin
		if (srst)
			freeze_ff <= `RTCPF_FREEZE_RST;
		else if (pf_event)
			freeze_ff <= 1'b1; // see (R15)
		else if (wr_hold)
			freeze_ff <= rx_byte[`RTCPF_BIT_FREEZE]; // see (R16)
	end

	// internal timekeeping; stop bit and divider reset live inside
	rtcpf_tod #(
		.OSC_DIV (OSC_DIV)
	) u_tod (
		.clk      (clk),
		.srst     (srst),
		.wr_en    (wr_clock), // see (R19) (R12) (R13)
		.wr_idx   (ptr_ff[2:0]),
		.wr_data  (rx_byte),
		.tick_32k (tick_32k),
		.time_q   (time_int)
	);

	// supervisor pins; the sram path costs two clocks of sync latency
	always_ff @(posedge clk) begin
		if (srst) begin
			sram_en_ff   <= 1'b1;
			sram_oe_n_ff <= 1'b0;
			rst_n_ff     <= 1'b0;
			rst_oe_n_ff  <= 1'b0;
		end else begin
			sram_en_ff   <= ext_s2_ff | ~running; // see (R3) (R4)
			sram_oe_n_ff <= on_batt; // see (R6)
			rst_n_ff     <= running; // see (R2) (R5)
			rst_oe_n_ff  <= on_batt; // see (R6)
		end
	end

	assign sdo             = sdo_ff;
	assign sdo_oe_n        = sdo_oe_n_ff;
	assign sram_enable_out = sram_en_ff;
	assign sram_oe_n       = sram_oe_n_ff;
	assign cpu_reset_n     = rst_n_ff;
	assign cpu_reset_oe_n  = rst_oe_n_ff;

endmodule : rtcpf_clock_pf

// ==== src/rtcpf_pkg.sv ====
package rtcpf_pkg;

	// eight BCD time bytes, index = clock register address
	typedef logic [7:0][7:0] rtcpf_time_t;

	// serial port pins as seen by the device
	typedef struct packed {
		logic scl;
		logic sdi;
		logic ce_n;
	} rtcpf_spi_in_t;

	// digital view of the supply comparators
	typedef struct packed {
		logic pwr_fail;
		logic on_battery;
		logic supply_ok;
	} rtcpf_supply_t;

	// power sequencing, gray along run-fail-batt-rec
	typedef enum logic [1:0] {
		PS_RUN  = 2'b00,
		PS_FAIL = 2'b01,
		PS_BATT = 2'b11,
		PS_REC  = 2'b10
	} rtcpf_pwr_t;

endpackage : rtcpf_pkg

// ==== src/rtcpf_regs.svh ====
`ifndef RTCPF_REGS_SVH
`define RTCPF_REGS_SVH

// register addresses on the serial port (6-bit pointer)
`define RTCPF_ADDR_HSEC      6'h00
`define RTCPF_ADDR_SEC       6'h01
`define RTCPF_ADDR_MIN       6'h02
`define RTCPF_ADDR_HOUR      6'h03
`define RTCPF_ADDR_DOW       6'h04
`define RTCPF_ADDR_DATE      6'h05
`define RTCPF_ADDR_MONTH     6'h06
`define RTCPF_ADDR_YEAR      6'h07
`define RTCPF_ADDR_CTRL      6'h08
`define RTCPF_ADDR_HOLD      6'h0C
`define RTCPF_CLOCK_REGS     6'h08

// byte indices inside the time array
`define RTCPF_IDX_HSEC       3'h0
`define RTCPF_IDX_SEC        3'h1
`define RTCPF_IDX_MIN        3'h2
`define RTCPF_IDX_HOUR       3'h3
`define RTCPF_IDX_DOW        3'h4
`define RTCPF_IDX_DATE       3'h5
`define RTCPF_IDX_MONTH      3'h6
`define RTCPF_IDX_YEAR       3'h7

// field positions
`define RTCPF_BIT_STOP       7
`define RTCPF_BIT_CENT_EN    7
`define RTCPF_BIT_CENT_FLAG  6
`define RTCPF_BIT_POWER_UP_DESELECT_TIME_SEL   7
`define RTCPF_BIT_FREEZE     6

// reset values
`define RTCPF_CTRL_RST       8'h00
`define RTCPF_ONE_RST        8'h01
`define RTCPF_FREEZE_RST     1'b0

// timing
`define RTCPF_CLK_HZ         40000000
`define RTCPF_OSC_HZ         32768
`define RTCPF_HSEC_STEP      100
`define RTCPF_POWER_UP_DESELECT_TIME_SHORT_US  50
`define RTCPF_POWER_UP_DESELECT_TIME_LONG_US   2000

`endif

// ==== src/rtcpf_tod.sv ====
`include "rtcpf_regs.svh"

module rtcpf_tod #(
	parameter int OSC_DIV = `RTCPF_CLK_HZ / `RTCPF_OSC_HZ
) (
	input  wire logic                 clk,
	input  wire logic                 srst,
	input  wire logic                 wr_en,
	input  wire logic [2:0]           wr_idx,
	input  wire logic [7:0]           wr_data,
	output wire logic                 tick_32k,
	output rtcpf_pkg::rtcpf_time_t    time_q
);
	import rtcpf_pkg::*;

	logic [10:0]  div_ff;
	logic [14:0]  acc_ff;
	rtcpf_time_t  t_ff;

	// bcd step with wrap; >= recovers from illegal values
	function automatic logic [8:0] bcd_step(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		if (v >= hi)
			return {1'b1, lo};
		else if (v[3:0] >= 4'h9)
			return {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			return {1'b0, v + 8'h01};
	endfunction : bcd_step

	// last day of month in bcd, leap years from the bcd year
	function automatic logic [7:0] last_day(input logic [7:0] mon,
		input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
			8'h02:                      return leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default:                    return 8'h31;
		endcase
	endfunction : last_day

	// 32 kHz enable and hundredths accumulator (32768/100 is not whole)
	wire         stopped = t_ff[`RTCPF_IDX_SEC][`RTCPF_BIT_STOP];
	wire [15:0]  acc_sum = {1'b0, acc_ff} + 16'(`RTCPF_HSEC_STEP);
	wire         acc_ovf = acc_sum >= 16'(`RTCPF_OSC_HZ);
	wire [15:0]  acc_rem = acc_sum - 16'(`RTCPF_OSC_HZ);
	assign tick_32k = div_ff == 11'(OSC_DIV - 1);
	wire         hs_tick = tick_32k & ~stopped & acc_ovf; // see (R12)

	always_ff @(posedge clk) begin
		if (srst || wr_en) begin // see (R19)
			div_ff <= 11'h000;
			acc_ff <= 15'h0000;
		end else begin
			div_ff <= tick_32k ? 11'h000 : div_ff + 11'h001;
			if (tick_32k && !stopped)
				acc_ff <= acc_ovf ? acc_rem[14:0] : acc_sum[14:0];
		end
	end

	// carry cascade through the bcd fields
	wire [8:0] hs_n  = bcd_step(t_ff[`RTCPF_IDX_HSEC], 8'h00, 8'h99);
	wire [8:0] sec_n = bcd_step({1'b0, t_ff[`RTCPF_IDX_SEC][6:0]},
		8'h00, 8'h59);
	wire [8:0] min_n = bcd_step({1'b0, t_ff[`RTCPF_IDX_MIN][6:0]},
		8'h00, 8'h59);
	wire [8:0] hr_n  = bcd_step({2'b00, t_ff[`RTCPF_IDX_HOUR][5:0]},
		8'h00, 8'h23);
	wire [8:0] dow_n = bcd_step({5'h00, t_ff[`RTCPF_IDX_DOW][2:0]},
		8'h01, 8'h07);
	wire [8:0] dt_n  = bcd_step({2'b00, t_ff[`RTCPF_IDX_DATE][5:0]},
		8'h01, last_day(t_ff[`RTCPF_IDX_MONTH], t_ff[`RTCPF_IDX_YEAR]));
	wire [8:0] mo_n  = bcd_step({3'h0, t_ff[`RTCPF_IDX_MONTH][4:0]},
		8'h01, 8'h12);
	wire [8:0] yr_n  = bcd_step(t_ff[`RTCPF_IDX_YEAR], 8'h00, 8'h99);
	wire c_s   = hs_tick & hs_n[8];
	wire c_m   = c_s & sec_n[8];
	wire c_h   = c_m & min_n[8];
	wire c_d   = c_h & hr_n[8];
	wire c_mo  = c_d & dt_n[8];
	wire c_yr  = c_mo & mo_n[8];
	wire ceb   = t_ff[`RTCPF_IDX_HOUR][`RTCPF_BIT_CENT_EN];
	wire cb_n  = t_ff[`RTCPF_IDX_HOUR][`RTCPF_BIT_CENT_FLAG]
		^ (c_yr & yr_n[8] & ceb); // see (R9)

	// internal time: host write wins over counting
	always_ff @(posedge clk) begin
		if (srst) begin
			t_ff <= '0;
			t_ff[`RTCPF_IDX_DOW]   <= `RTCPF_ONE_RST;
			t_ff[`RTCPF_IDX_DATE]  <= `RTCPF_ONE_RST;
			t_ff[`RTCPF_IDX_MONTH] <= `RTCPF_ONE_RST;
		end else if (wr_en) begin
			t_ff[wr_idx] <= wr_data; // see (R8)
		end else begin
			if (hs_tick)
				t_ff[`RTCPF_IDX_HSEC] <= hs_n[7:0];
			if (c_s)
				t_ff[`RTCPF_IDX_SEC][6:0] <= sec_n[6:0];
			if (c_m)
				t_ff[`RTCPF_IDX_MIN][6:0] <= min_n[6:0];
			if (c_h)
				t_ff[`RTCPF_IDX_HOUR] <= {ceb, cb_n, hr_n[5:0]};
			if (c_d) begin
				t_ff[`RTCPF_IDX_DOW][2:0]  <= dow_n[2:0]; // see (R10)
				t_ff[`RTCPF_IDX_DATE][5:0] <= dt_n[5:0];
			end
			if (c_mo)
				t_ff[`RTCPF_IDX_MONTH][4:0] <= mo_n[4:0];
			if (c_yr)
				t_ff[`RTCPF_IDX_YEAR] <= yr_n[7:0];
		end
	end

	assign time_q = t_ff;

endmodule : rtcpf_tod

// ==== tb/rtcpf_clock_pf_chk.sv ====
`include "rtcpf_regs.svh"

module rtcpf_clock_pf_chk #(
	parameter int OSC_DIV = `RTCPF_CLK_HZ / `RTCPF_OSC_HZ
) (
	input  wire logic                clk,
	input  wire logic                srst,
	input  wire logic                sdo_oe_n,
	input  rtcpf_pkg::rtcpf_supply_t supply,
	input  wire logic                ext_ce_n,
	input  wire logic                sram_enable_out,
	input  wire logic                sram_oe_n,
	input  wire logic                cpu_reset_n,
	input  wire logic                cpu_reset_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	import rtcpf_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	logic [23:0] low_ff;
	// length of the current reset pulse; wide enough for the long interval
	always_ff @(posedge clk)
		low_ff <= (srst || cpu_reset_n) ? 24'h000000 : low_ff + 24'h000001;

	rst_on_fail_a: assert property (
		$rose(supply.pwr_fail) |-> ##[1:5] !cpu_reset_n)
		else $error("reset late on fail");
	rst_hold_a: assert property (
		!cpu_reset_n && !supply.supply_ok |=> !cpu_reset_n)
		else $error("reset left early");
	rst_release_a: assert property (
		$rose(cpu_reset_n) |-> supply.supply_ok && !supply.pwr_fail)
		else $error("bad release");
	sram_block_a: assert property (
		supply.pwr_fail[*6] |-> sram_enable_out)
		else $error("sram enabled in fail");
	sram_follow_a: assert property (
		(cpu_reset_n && !ext_ce_n && !supply.pwr_fail)[*6]
		|-> !sram_enable_out)
		else $error("sram stuck off");
	protect_span_a: assert property (
		$rose(cpu_reset_n) |-> $past(sram_enable_out, 3))
		else $error("sram freed early");
	interval_min_a: assert property (
		$rose(cpu_reset_n) |-> low_ff >= OSC_DIV)
		else $error("interval too short");
	batt_hiz_a: assert property (
		supply.on_battery[*6] |-> sram_oe_n && cpu_reset_oe_n)
		else $error("driven on battery");
	run_drive_a: assert property (
		(!supply.on_battery)[*6] |-> !sram_oe_n && !cpu_reset_oe_n)
		else $error("pins float");
	fail_abort_a: assert property (
		$rose(supply.pwr_fail) |-> ##[1:5] sdo_oe_n)
		else $error("read not aborted");

	cover property ($rose(cpu_reset_n));
	cover property (supply.on_battery[*6]);
	cover property ($fell(sdo_oe_n));
endmodule : rtcpf_clock_pf_chk

bind rtcpf_clock_pf rtcpf_clock_pf_chk #(.OSC_DIV(OSC_DIV)) u_chk (
	.clk(clk), .srst(srst), .sdo_oe_n(sdo_oe_n), .supply(supply),
	.ext_ce_n(ext_ce_n), .sram_enable_out(sram_enable_out),
	.sram_oe_n(sram_oe_n), .cpu_reset_n(cpu_reset_n),
	.cpu_reset_oe_n(cpu_reset_oe_n)
);

// ==== tb/rtcpf_host.sv ====
module rtcpf_host (
	input  wire logic                clk,
	output rtcpf_pkg::rtcpf_spi_in_t spi_in,
	input  wire logic                sdo,
	input  wire logic                sdo_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	import rtcpf_pkg::*;

	// idle: deselected, mode 0 clock parked low
	initial spi_in = '{scl: 1'b0, sdi: 1'b1, ce_n: 1'b1};

	// six clocks a phase, well past the pin synchroniser lag
	task automatic half();
		repeat (6) @(posedge clk);
	endtask : half

	// one byte msb first; sdi moves only while scl is low
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			spi_in.sdi <= tx[i];
			half();
			spi_in.scl <= 1'b1;
			rx[i] = sdo_oe_n ? 1'bx : sdo; // undriven line means nothing
			half();
			spi_in.scl <= 1'b0;
		end
	endtask : xbyte

	// command byte, n data bytes in place, then deselect
	task automatic txn(input logic wr, input logic [5:0] addr,
		input int n, inout logic [7:0] d [8]);
		logic [7:0] junk;
		spi_in.ce_n <= 1'b0;
		half();
		xbyte({wr, 1'b0, addr}, junk);
		for (int k = 0; k < n; k++)
			xbyte(d[k], d[k]);
		half();
		spi_in.ce_n <= 1'b1;
		spi_in.sdi <= ~spi_in.sdi; // released line must not keep its level
		half();
	endtask : txn
endmodule : rtcpf_host

// ==== tb/tb_rtcpf_clock_pf.sv ====
module tb_rtcpf_clock_pf;
	timeunit 1ns;
	timeprecision 1ps;
	import rtcpf_pkg::*;
	localparam int OSC_DIV = 4;

	logic          clk, srst, ext_ce_n, sdo, sdo_oe_n;
	logic          sram_enable_out, sram_oe_n, cpu_reset_n, cpu_reset_oe_n;
	rtcpf_spi_in_t spi_in;
	rtcpf_supply_t supply;
	int            n_errors, check_count;
	logic [7:0]    d [8];

	rtcpf_clock_pf #(.OSC_DIV(OSC_DIV)) dut (
		.clk(clk), .srst(srst), .spi_in(spi_in), .sdo(sdo),
		.sdo_oe_n(sdo_oe_n), .supply(supply), .ext_ce_n(ext_ce_n),
		.sram_enable_out(sram_enable_out), .sram_oe_n(sram_oe_n),
		.cpu_reset_n(cpu_reset_n), .cpu_reset_oe_n(cpu_reset_oe_n)
	);
	rtcpf_host host (
		.clk(clk), .spi_in(spi_in), .sdo(sdo), .sdo_oe_n(sdo_oe_n)
	);

	// 40 MHz
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic give_verdict();
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr1(input logic [5:0] a, input logic [7:0] v);
		d[0] = v;
		host.txn(1'b1, a, 1, d);
	endtask : wr1

	task automatic rd1(input logic [5:0] a, output logic [7:0] v);
		host.txn(1'b0, a, 1, d);
		v = d[0];
	endtask : rd1

	// clocks until the processor reset lets go, bounded
	task automatic wait_run(output int cyc);
		cyc = 0;
		while (cpu_reset_n !== 1'b1 && cyc < 2000) begin
			@(posedge clk);
			cyc++;
		end
	endtask : wait_run

	// long deselect interval after reset, then default contents
	task automatic s_reset();
		int cyc;
		logic [7:0] v;
		logic ok;
		wait_run(cyc);
		ok = cyc >= 65 * OSC_DIV && cyc <= 69 * OSC_DIV;
		check({7'h00, ok}, 8'h01);
		for (int i = 4; i < 9; i++) begin
			rd1(6'(i), v);
			check(v, (i > 6) ? 8'h00 : 8'h01);
		end
		wr1(6'h08, 8'hA5);
		rd1(6'h08, v);
		check(v, 8'hA5);
	endtask : s_reset

	// last hundredth of the century, then one step over it
	task automatic s_century(input logic ceb);
		logic [7:0] e [8];
		d = '{8'h99, 8'h59, 8'h59, {ceb, 7'h63}, 8'h07, 8'h31, 8'h12, 8'h99};
		e = '{8'h00, 8'h00, 8'h00, {ceb, ~ceb, 6'h00},
			8'h01, 8'h01, 8'h01, 8'h00};
		host.txn(1'b1, 6'h00, 8, d);
		repeat (1800) @(posedge clk);
		host.txn(1'b0, 6'h00, 8, d);
		for (int i = 0; i < 8; i++)
			check(d[i], e[i]);
	endtask : s_century

	// stop bit holds the count, clearing it resumes
	task automatic s_stop();
		logic [7:0] v0, v1;
		wr1(6'h01, 8'h80);
		rd1(6'h00, v0);
		repeat (3000) @(posedge clk);
		rd1(6'h00, v1);
		check(v1, v0);
		rd1(6'h01, v1);
		check({v1[7], 7'h00}, 8'h80);
		wr1(6'h01, 8'h00);
		repeat (2000) @(posedge clk);
		rd1(6'h00, v1);
		check({7'h00, v1 != v0}, 8'h01);
	endtask : s_stop

	// fail cuts a read, battery, short recovery, frozen time, host thaw
	task automatic s_power();
		int cyc;
		logic [7:0] v, t0;
		logic ok;
		wr1(6'h04, 8'h81); // short interval so recovery is quick
		wr1(6'h08, 8'h3C);
		ext_ce_n <= 1'b0;
		repeat (8) @(posedge clk);
		check({7'h00, sram_enable_out}, 8'h00);
		fork
			host.txn(1'b0, 6'h00, 8, d);
			begin
				// fail lands in the middle of the read burst
				repeat (300) @(posedge clk);
				supply <= '{pwr_fail: 1'b1, on_battery: 1'b0,
					supply_ok: 1'b0};
				repeat (8) @(posedge clk);
				v = {6'h00, sram_enable_out, cpu_reset_n};
				check(v, 8'h02);
				check({7'h00, sdo_oe_n}, 8'h01);
			end
		join
		wr1(6'h08, 8'h00);
		supply.on_battery <= 1'b1;
		repeat (8) @(posedge clk);
		check({6'h00, sram_oe_n, cpu_reset_oe_n}, 8'h03);
		supply.on_battery <= 1'b0;
		repeat (8) @(posedge clk);
		supply <= '{pwr_fail: 1'b0, on_battery: 1'b0, supply_ok: 1'b1};
		wait_run(cyc);
		ok = cyc >= OSC_DIV && cyc <= 5 * OSC_DIV;
		check({7'h00, ok}, 8'h01);
		rd1(6'h08, v);
		check(v, 8'h3C);
		rd1(6'h0C, v);
		check(v, 8'h40);
		rd1(6'h00, t0);
		repeat (2000) @(posedge clk);
		rd1(6'h00, v);
		check(v, t0);
		wr1(6'h0C, 8'h00);
		repeat (2000) @(posedge clk);
		rd1(6'h00, v);
		check({7'h00, v != t0}, 8'h01);
	endtask : s_power

	initial begin
		srst = 1'b1;
		ext_ce_n = 1'b1;
		supply = '{pwr_fail: 1'b0, on_battery: 1'b0, supply_ok: 1'b1};
		n_errors = 0;
		check_count = 0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		s_reset();
		s_century(1'b1);
		s_century(1'b0);
		s_stop();
		s_power();
		give_verdict();
	end

	// nearly three times the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		give_verdict();
	end
endmodule : tb_rtcpf_clock_pf
